// [dv/board_model.sv]
// Board side: pulled-up aux wires and free-running board clocks
`timescale 1ns/1ns
`default_nettype none
module board_model (
  input  wire logic [2:0] AUX_OE,
  input  wire logic [2:0] aux_ext,
  output var  logic [2:0] AUX_I,
  output var  logic       OSC_CLK_IN,
  output var  logic       DATA_CLK_IN
);
  // Pulled up; low when the device or the board pulls down
  always_comb AUX_I = aux_ext & ~AUX_OE;
  // Oscillator near its nominal rate, period 13 CLK periods, each rise landing on a CLK rise
  initial
  begin
    OSC_CLK_IN = 1'b0;
    forever #65 OSC_CLK_IN = ~OSC_CLK_IN;
  end
  // Bus data clock from the board; half period never lands on a CLK rise
  initial
  begin
    DATA_CLK_IN = 1'b0;
    forever #164 DATA_CLK_IN = ~DATA_CLK_IN;
  end
endmodule
`default_nettype wire

// [dv/misc_ctrl_monitor.sv]
// Concurrent checks on the strap, aux port, reset and indicator outputs
`timescale 1ns/1ns
`default_nettype none
module misc_ctrl_monitor #(
  parameter int RST_CYC = 4
) (
  input wire logic       CLK,
  input wire logic       RST_B,
  input wire logic       MODE_PRI,
  input wire logic       MODE_SEC,
  input wire logic [2:0] AUX_I,
  input wire logic [2:0] AUX_O,
  input wire logic [2:0] AUX_OE,
  input wire logic       RX_DBIT,
  input wire logic       DCHAN_ACT_OUT,
  input wire logic       WDOG_EXPIRE,
  input wire logic       RESET_OUT_O,
  input wire logic       RESET_OUT_OE,
  input wire logic       OSC_CLK_IN,
  input wire logic       OSC_CLK_OUT,
  input wire logic       DATA_CLK_IN,
  input wire logic       S_CLK_1536,
  input wire logic       BIT_CLK_OUT,
  input wire logic       ECHO_INVERT,
  input wire logic [2:0] BUS_CHAN_SEL,
  input wire logic [1:0] ROLE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic [7:0] oe_cnt; // Cycles the reset pin has been pulled
  // Length of the current reset pulse
  always_ff @(posedge CLK)
    oe_cnt <= (!RST_B || !RESET_OUT_OE) ? 8'h00 : oe_cnt + 8'h01;
  AST_ROLE_TE: assert property ((!MODE_PRI)[*4] |=> ROLE == 2'h0)
    else $error("role not subscriber with primary strap low");
  AST_ROLE_LTT: assert property ((MODE_PRI && !MODE_SEC)[*4] |=> ROLE == 2'h1)
    else $error("role not trunk with straps 1,0");
  AST_CHSEL: assert property ((ROLE != 2'h0 && $stable(AUX_I))[*4] |=> BUS_CHAN_SEL == $past(AUX_I))
    else $error("channel select does not follow aux pins");
  AST_AUX_IN: assert property (ROLE != 2'h0 |-> AUX_OE == 3'h0)
    else $error("aux pin driven outside subscriber role");
  AST_OPEN_DRAIN: assert property (AUX_O == 3'h0 && !RESET_OUT_O)
    else $error("open drain pin driven high");
  AST_RESET_OUT_PIN_WD: assert property (WDOG_EXPIRE |=> RESET_OUT_OE)
    else $error("no reset output after watchdog expiry");
  AST_RESET_OUT_PIN_LEN: assert property ($fell(RESET_OUT_OE) |-> oe_cnt == RST_CYC)
    else $error("reset output pulse length wrong");
  AST_OSC: assert property ($stable(OSC_CLK_IN)[*4] |=> OSC_CLK_OUT == $past(OSC_CLK_IN))
    else $error("oscillator output does not follow oscillator");
  AST_DCA: assert property (1'b1 |=> DCHAN_ACT_OUT == $past(RX_DBIT))
    else $error("activity output does not follow received bits");
  AST_ECHO_OFF: assert property (ROLE[1] == 1'b0 |-> !ECHO_INVERT)
    else $error("echo inverted in subscriber or trunk role");
  AST_BITCLK: assert property ((ROLE == 2'h1 && $stable(S_CLK_1536))[*4] |=> BIT_CLK_OUT == $past(S_CLK_1536))
    else $error("trunk bit clock does not follow locked clock");
  // Outside trunk role each data clock rise toggles the bit clock after the sync delay
  AST_BITCLK_DIV: assert property ((ROLE != 2'h1 && $rose(DATA_CLK_IN)) ##2 (ROLE != 2'h1) |=> $changed(BIT_CLK_OUT))
    else $error("bit clock does not toggle on data clock rise");
endmodule
bind misc_ctrl misc_ctrl_monitor #(.RST_CYC(RST_CYC)) misc_ctrl_monitor_inst (.CLK, .RST_B, .MODE_PRI,
  .MODE_SEC, .AUX_I, .AUX_O, .AUX_OE, .RX_DBIT, .DCHAN_ACT_OUT, .WDOG_EXPIRE, .RESET_OUT_O, .RESET_OUT_OE,
  .OSC_CLK_IN, .OSC_CLK_OUT, .DATA_CLK_IN, .S_CLK_1536, .BIT_CLK_OUT, .ECHO_INVERT, .BUS_CHAN_SEL, .ROLE);
`default_nettype wire

// [dv/misc_ctrl_tb_top.sv]
// Self-checking bench for the strap, aux port, reset output and indicators
`timescale 1ns/1ns
`default_nettype none
module misc_ctrl_tb_top;
  logic        CLK, RST_B, MODE_PRI, MODE_SEC, ECHO_INHIBIT_IN, S_CLK_1536, RX_DBIT, S_ACTIVATED;
  logic        WDOG_EXPIRE, SG_STROBE, AWVALID, WVALID, BREADY, ARVALID, RREADY, rst_seen;
  logic [31:0] AWADDR, WDATA, ARADDR;
  logic [3:0]  WSTRB;
  logic [2:0]  aux_ext;
  wire  [2:0]  AUX_I, AUX_O, AUX_OE, BUS_CHAN_SEL;
  wire  [31:0] RDATA;
  wire  [1:0]  BRESP, RRESP, ROLE;
  wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, INT, OSC_CLK_IN, DATA_CLK_IN, RESET_OUT_O;
  wire         RESET_OUT_OE, OSC_CLK_OUT, BIT_CLK_OUT, DCHAN_ACT_OUT, ECHO_INVERT, STOP_GO_OUT, ACT_LED_OUT;
  int          error_cnt, comparisons, cycles, n;
  misc_ctrl #(.RST_CYC(4)) misc_ctrl_inst (.CLK, .RST_B, .CE(1'b1), .MODE_PRI, .MODE_SEC, .AUX_I, .AUX_O,
    .AUX_OE, .ECHO_INHIBIT_IN, .OSC_CLK_IN, .DATA_CLK_IN, .S_CLK_1536, .RX_DBIT, .S_ACTIVATED, .WDOG_EXPIRE,
    .SG_STROBE, .RESET_OUT_O, .RESET_OUT_OE, .OSC_CLK_OUT, .BIT_CLK_OUT, .DCHAN_ACT_OUT, .ECHO_INVERT,
    .STOP_GO_OUT, .ACT_LED_OUT, .BUS_CHAN_SEL, .ROLE, .INT, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
    .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
  board_model board_model_inst (.AUX_OE, .aux_ext, .AUX_I, .OSC_CLK_IN, .DATA_CLK_IN);
  // System clock and an unrelated locked bit clock
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  always #326 S_CLK_1536 = ~S_CLK_1536;
  // Cycle ceiling and reset-pin watcher
  always @(posedge CLK)
  begin
    cycles++;
    if (RESET_OUT_OE === 1'b1) rst_seen <= 1'b1;
    if (cycles == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge CLK);
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [31:0] a, d, input logic [1:0] er = 2'h0);
    logic aw, w;
    @(posedge CLK);
    aw = 1'b0;
    w = 1'b0;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge CLK);
      aw = aw || AWREADY === 1'b1;
      w = w || WREADY === 1'b1;
      AWVALID <= !aw;
      WVALID <= !w;
    end
    do @(posedge CLK); while (BVALID !== 1'b1);
    chk("BRESP", 32'(er), 32'(BRESP));
    BREADY <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a, e, input logic [1:0] er = 2'h0);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(posedge CLK); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    do @(posedge CLK); while (RVALID !== 1'b1);
    chk("RDATA", e, RDATA);
    chk("RRESP", 32'(er), 32'(RRESP));
    RREADY <= 1'b0;
  endtask
  // Straps change here while reset is held; the awake test later drops MODE_SEC outside reset
  task automatic rst(input logic p, s);
    RST_B <= 1'b0;
    MODE_PRI <= p;
    MODE_SEC <= s;
    cyc(10);
    RST_B <= 1'b1;
    cyc(4);
  endtask
  task automatic end_of_test();
    $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {RST_B, MODE_PRI, MODE_SEC, ECHO_INHIBIT_IN, S_CLK_1536, RX_DBIT, S_ACTIVATED, WDOG_EXPIRE} = 8'h00;
    {SG_STROBE, AWVALID, WVALID, BREADY, ARVALID, RREADY, rst_seen} = 7'h00;
    {AWADDR, WDATA, ARADDR, WSTRB, aux_ext} = {96'h0, 4'hF, 3'h7};
    rst(1'b0, 1'b1);
    chk("ROLE", 32'h0, 32'(ROLE));
    axi_rd(32'h14, 32'h0);
    axi_rd(32'h0, 32'h101);
    axi_rd(32'h8, 32'h7);
    axi_rd(32'h1C, 32'h0, 2'h2);
    axi_wr(32'h20, 32'h1, 2'h2);
    axi_wr(32'h4, 32'h5);
    axi_wr(32'h8, 32'h0);
    aux_ext <= 3'h6;
    cyc(4);
    chk("AUX_OE", 32'h5, 32'(AUX_OE));
    axi_rd(32'hC, 32'h2);
    S_ACTIVATED <= 1'b1;
    cyc(3);
    chk("ACT_LED_OUT", 32'h0, 32'(ACT_LED_OUT));
    axi_wr(32'h0, 32'h30A);
    cyc(2);
    chk("ACT_LED_OUT", 32'h1, 32'(ACT_LED_OUT));
    SG_STROBE <= 1'b1;
    @(posedge CLK);
    SG_STROBE <= 1'b0;
    n = 0;
    repeat (10)
    begin
      @(posedge CLK);
      n += (STOP_GO_OUT === 1'b1);
    end
    chk("stop_go_len", 32'h3, 32'(n));
    axi_wr(32'h18, 32'h3);
    axi_wr(32'h0, 32'h31A);
    rst_seen <= 1'b0;
    MODE_SEC <= 1'b0;
    cyc(8);
    chk("INT", 32'h1, 32'(INT));
    chk("rst_seen", 32'h1, 32'(rst_seen));
    axi_rd(32'h14, 32'h1);
    axi_wr(32'h14, 32'h1);
    axi_rd(32'h14, 32'h0);
    chk("INT", 32'h0, 32'(INT));
    axi_wr(32'h18, 32'h0);
    WDOG_EXPIRE <= 1'b1;
    @(posedge CLK);
    WDOG_EXPIRE <= 1'b0;
    cyc(6);
    chk("INT", 32'h0, 32'(INT));
    axi_rd(32'h14, 32'h2);
    rst_seen <= 1'b0;
    axi_wr(32'h0, 32'h20);
    cyc(2);
    chk("rst_seen", 32'h1, 32'(rst_seen));
    for (int i = 0; i < 2; i++)
    begin
      rst(1'b1, i[0]);
      chk("ROLE", 32'(i + 1), 32'(ROLE));
      aux_ext <= 3'h5;
      ECHO_INHIBIT_IN <= 1'b1;
      cyc(5);
      chk("BUS_CHAN_SEL", 32'h5, 32'(BUS_CHAN_SEL));
      chk("ECHO_INVERT", 32'(i), 32'(ECHO_INVERT));
    end
    ECHO_INHIBIT_IN <= 1'b0;
    axi_wr(32'h0, 32'h145);
    cyc(4);
    chk("ROLE", 32'h3, 32'(ROLE));
    chk("ECHO_INVERT", 32'h1, 32'(ECHO_INVERT));
    axi_rd(32'h10, 32'h37);
    RX_DBIT <= 1'b1;
    cyc(2);
    chk("DCHAN_ACT_OUT", 32'h1, 32'(DCHAN_ACT_OUT));
    end_of_test();
  end
endmodule
`default_nettype wire

// [rtl/misc_ctrl.v]
// Strap, auxiliary port, reset output and indicator logic with AXI4-Lite registers
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "misc_defs.vh"
module misc_ctrl #(
  parameter RST_CYC = `RST_PULSE_CYC
) (
  input  wire        CLK,
  input  wire        RST_B,
  input  wire        CE,
  input  wire        MODE_PRI,
  input  wire        MODE_SEC,
  input  wire [2:0]  AUX_I,
  output reg  [2:0]  AUX_O,
  output reg  [2:0]  AUX_OE,
  input  wire        ECHO_INHIBIT_IN,
  input  wire        OSC_CLK_IN,
  input  wire        DATA_CLK_IN,
  input  wire        S_CLK_1536,
  input  wire        RX_DBIT,
  input  wire        S_ACTIVATED,
  input  wire        WDOG_EXPIRE,
  input  wire        SG_STROBE,
  output reg         RESET_OUT_O,
  output reg         RESET_OUT_OE,
  output reg         OSC_CLK_OUT,
  output reg         BIT_CLK_OUT,
  output reg         DCHAN_ACT_OUT,
  output reg         ECHO_INVERT,
  output reg         STOP_GO_OUT,
  output reg         ACT_LED_OUT,
  output reg  [2:0]  BUS_CHAN_SEL,
  output reg  [1:0]  ROLE,
  output reg         INT,
  input  wire [31:0] AWADDR,
  input  wire        AWVALID,
  output reg         AWREADY,
  input  wire [31:0] WDATA,
  input  wire [3:0]  WSTRB,
  input  wire        WVALID,
  output reg         WREADY,
  output reg  [1:0]  BRESP,
  output reg         BVALID,
  input  wire        BREADY,
  input  wire [31:0] ARADDR,
  input  wire        ARVALID,
  output reg         ARREADY,
  output reg  [31:0] RDATA,
  output reg  [1:0]  RRESP,
  output reg         RVALID,
  input  wire        RREADY
);

  // Word index decode; all-ones marks an unmapped address
  function [3:0] reg_index;
    input [31:0] addr;
    begin
      if (addr[31:5] != 27'h0 || addr[1:0] != 2'h0 || addr[4:2] == 3'h7)
        reg_index = 4'hF;
      else
        reg_index = {1'b0, addr[4:2]};
    end
  endfunction

  // Two-stage synchronisers for pins: straps, aux, inhibit, clocks
  reg  [8:0]  meta_r;                 // First stage, read only by second
  reg  [8:0]  sync_r;                 // Second stage
  wire [8:0]  pins = {OSC_CLK_IN, DATA_CLK_IN, ECHO_INHIBIT_IN, AUX_I, MODE_SEC, MODE_PRI, S_CLK_1536};
  wire        s_lt1536 = sync_r[0];   // Trunk bit clock from transceiver
  wire        s_pri    = sync_r[1];   // Primary strap
  wire        s_sec    = sync_r[2];   // Secondary strap or awake
  wire [2:0]  s_aux    = sync_r[5:3]; // Aux pin levels
  wire        s_inh    = sync_r[6];   // Inhibit pin
  wire        s_dcl    = sync_r[7];   // Data clock
  wire        s_osc    = sync_r[8];   // Oscillator clock

  // Registers
  reg  [31:0] conf_r;                 // Configuration
  reg  [2:0]  aux_dir_r;              // 1 = output
  reg  [2:0]  aux_out_r;              // Output levels
  reg  [1:0]  irq_stat_r;             // Sticky events
  reg  [1:0]  irq_mask_r;             // 1 = enabled
  reg         sec_d_r;                // Delayed awake level
  reg         dcl_d_r;                // Delayed data clock
  reg  [15:0] rst_cnt_r;              // Reset pulse counter
  reg  [7:0]  sg_cnt_r;               // Stop/go pulse counter

  // AXI state
  reg  [31:0] awaddr_r;               // Held write address
  reg  [31:0] wdata_r;                // Held write data
  reg  [3:0]  wstrb_r;                // Held strobes
  reg         aw_got_r;               // Address taken
  reg         w_got_r;                // Data taken

  // Role from straps; network role chosen by config in line card mode
  wire [1:0]  role_nxt = !s_pri ? `ROLE_TE :                      // R3
                         !s_sec ? `ROLE_LTT :                     // R4
                         conf_r[`CF_NT_SEL] ? `ROLE_NT : `ROLE_LTS; // R4
  wire        is_te    = (ROLE == `ROLE_TE);

  // Awake falling edge, only meaningful in subscriber role
  wire        awake_ev = is_te && sec_d_r && !s_sec;               // R5

  // Write commit when both halves are held
  wire        wr_do    = aw_got_r && w_got_r && !BVALID;
  wire [3:0]  wr_idx   = reg_index(awaddr_r);
  wire        wr_conf  = wr_do && (wr_idx == `ADR_CONF);
  wire        wr_isr   = wr_do && (wr_idx == `ADR_IRQ_STAT);
  wire [1:0]  isr_clr  = (wr_isr && wstrb_r[0]) ? wdata_r[1:0] : 2'h0;
  wire [1:0]  isr_set  = {WDOG_EXPIRE, awake_ev};
  wire        host_rst = wr_conf && wstrb_r[0] && wdata_r[`CF_HOST_RST];

  // Byte-lane merge of a held write
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (st[k])
          merge[k*8 +: 8] = nw[k*8 +: 8];
    end
  endfunction

  // Synchroniser stages
  always @(posedge CLK)
  begin
    if (!RST_B)
    begin
      meta_r <= 9'h000;
      sync_r <= 9'h000;
    end
    else if (CE)
    begin
      meta_r <= pins;
      sync_r <= meta_r;
    end
  end

  // Configuration, aux and interrupt registers
  always @(posedge CLK)
  begin
    if (!RST_B)
    begin
      conf_r     <= `CONF_RESET;
      aux_dir_r  <= 3'h0;
      aux_out_r  <= 3'h7;
      irq_stat_r <= 2'h0;
      irq_mask_r <= 2'h0;
    end
    else if (CE)
    begin
      // Command bit never stored: it acts as a pulse
      if (wr_conf)
        conf_r <= merge(conf_r, wdata_r, wstrb_r) & ~(32'h1 << `CF_HOST_RST);
      if (wr_do && wr_idx == `ADR_AUX_DIR && wstrb_r[0])
        aux_dir_r <= wdata_r[2:0];                                 // R1
      if (wr_do && wr_idx == `ADR_AUX_OUT && wstrb_r[0])
        aux_out_r <= wdata_r[2:0];                                 // R1
      if (wr_do && wr_idx == `ADR_IRQ_MASK && wstrb_r[0])
        irq_mask_r <= wdata_r[1:0];
      // Set wins over a same-cycle clear
      irq_stat_r <= (irq_stat_r & ~isr_clr) | isr_set;             // R5
    end
  end

  // Edge detectors, role, indicators and pins
  always @(posedge CLK)
  begin
    if (!RST_B)
    begin
      // Low so an awake edge needs a high seen after reset
      sec_d_r       <= 1'b0;
      dcl_d_r       <= 1'b0;
      ROLE          <= `ROLE_TE;
      BUS_CHAN_SEL  <= 3'h0;
      OSC_CLK_OUT   <= 1'b0;
      BIT_CLK_OUT   <= 1'b0;
      DCHAN_ACT_OUT <= 1'b1;
      ECHO_INVERT   <= 1'b0;
      ACT_LED_OUT   <= 1'b1;
      INT           <= 1'b0;
    end
    else if (CE)
    begin
      sec_d_r       <= s_sec;
      dcl_d_r       <= s_dcl;
      ROLE          <= role_nxt;                                   // R3
      // Channel select follows aux pins outside subscriber role
      BUS_CHAN_SEL  <= is_te ? 3'h0 : s_aux;                       // R2
      OSC_CLK_OUT   <= s_osc;                                      // R7
      // Bit clock: trunk copies S clock, others halve data clock
      if (ROLE == `ROLE_LTT)
        BIT_CLK_OUT <= s_lt1536;                                   // R13
      else if (s_dcl && !dcl_d_r)
        BIT_CLK_OUT <= ~BIT_CLK_OUT;                               // R13
      DCHAN_ACT_OUT <= RX_DBIT;                                    // R8
      // Echo inversion only in network and line card roles
      ECHO_INVERT   <= (ROLE == `ROLE_NT || ROLE == `ROLE_LTS) &&
                       (s_inh || conf_r[`CF_INHIBIT]);             // R9
      // LED: auto low while activated, else host level
      ACT_LED_OUT   <= conf_r[`CF_LED_AUTO] ? !S_ACTIVATED : conf_r[`CF_LED_LEVEL]; // R11
      INT           <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Aux pin drivers, open drain, per pin
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : aux_pin
      always @(posedge CLK)
      begin
        if (!RST_B)
        begin
          AUX_O[g]  <= 1'b0;
          AUX_OE[g] <= 1'b0;
        end
        else if (CE)
        begin
          AUX_O[g]  <= 1'b0;
          // Drive low only for an output set to zero in subscriber role
          AUX_OE[g] <= is_te && aux_dir_r[g] && !aux_out_r[g];     // R1
        end
      end
    end
  endgenerate

  // Reset output pulse, open drain low
  always @(posedge CLK)
  begin
    if (!RST_B)
    begin
      rst_cnt_r    <= 16'h0;
      RESET_OUT_O  <= 1'b0;
      RESET_OUT_OE <= 1'b0;
    end
    else if (CE)
    begin
      RESET_OUT_O <= 1'b0;
      if (WDOG_EXPIRE || host_rst || (awake_ev && conf_r[`CF_AWAKE_RST])) // R6
        rst_cnt_r <= RST_CYC[15:0];                                // R5
      else if (rst_cnt_r != 16'h0)
        rst_cnt_r <= rst_cnt_r - 16'h1;
      RESET_OUT_OE <= (rst_cnt_r > 16'h1) ||
                      WDOG_EXPIRE || host_rst || (awake_ev && conf_r[`CF_AWAKE_RST]); // R6
    end
  end

  // Stop/go pulse with programmable length and polarity
  always @(posedge CLK)
  begin
    if (!RST_B)
    begin
      sg_cnt_r    <= 8'h0;
      STOP_GO_OUT <= 1'b0;
    end
    else if (CE)
    begin
      if (SG_STROBE)
        sg_cnt_r <= conf_r[`CF_SG_LEN_HI:`CF_SG_LEN_LO];           // R10
      else if (sg_cnt_r != 8'h0)
        sg_cnt_r <= sg_cnt_r - 8'h1;
      // Active level equals polarity bit, idle is its inverse
      STOP_GO_OUT <= (SG_STROBE || sg_cnt_r > 8'h1) ? conf_r[`CF_SG_POL] : !conf_r[`CF_SG_POL]; // R10
    end
  end

  // AXI write channel: address and data in either order
  always @(posedge CLK)
  begin
    if (!RST_B)
    begin
      AWREADY  <= 1'b0;
      WREADY   <= 1'b0;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 32'h0;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
      BVALID   <= 1'b0;
      BRESP    <= `RESP_OKAY;
    end
    else if (CE)
    begin
      AWREADY <= !aw_got_r && !AWREADY && !BVALID;
      WREADY  <= !w_got_r && !WREADY && !BVALID;
      if (AWVALID && AWREADY)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= AWADDR;
        AWREADY  <= 1'b0;
      end
      if (WVALID && WREADY)
      begin
        w_got_r <= 1'b1;
        wdata_r <= WDATA;
        wstrb_r <= WSTRB;
        WREADY  <= 1'b0;
      end
      if (wr_do)
      begin
        BVALID   <= 1'b1;
        BRESP    <= (wr_idx == 4'hF) ? `RESP_SLVERR : `RESP_OKAY;
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
      end
      else if (BVALID && BREADY)
        BVALID <= 1'b0;
    end
  end

  // AXI read channel: one cycle after address taken
  always @(posedge CLK)
  begin
    if (!RST_B)
    begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0;
      RRESP   <= `RESP_OKAY;
    end
    else if (CE)
    begin
      ARREADY <= !ARREADY && !RVALID && !ARVALID;
      if (ARVALID && !ARREADY && !RVALID)
        ARREADY <= 1'b1;
      if (ARVALID && ARREADY)
      begin
        ARREADY <= 1'b0;
        RVALID  <= 1'b1;
        RRESP   <= `RESP_OKAY;
        case (reg_index(ARADDR))
          `ADR_CONF:     RDATA <= conf_r;
          `ADR_AUX_DIR:  RDATA <= {29'h0, aux_dir_r};
          `ADR_AUX_OUT:  RDATA <= {29'h0, aux_out_r};
          `ADR_AUX_IN:   RDATA <= {29'h0, s_aux};                  // R1
          `ADR_STATUS:   RDATA <= {26'h0, S_ACTIVATED, BUS_CHAN_SEL, ROLE};
          `ADR_IRQ_STAT: RDATA <= {30'h0, irq_stat_r};
          `ADR_IRQ_MASK: RDATA <= {30'h0, irq_mask_r};
          default:
          begin
            RDATA <= 32'h0;
            RRESP <= `RESP_SLVERR;
          end
        endcase
      end
      else if (RVALID && RREADY)
        RVALID <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [rtl/misc_defs.vh]
// Register map, field positions and timing constants of the strap and pin logic
// Function
// R1 - Subscriber role: aux pins individually in/out
// R2 - Other roles: aux pins select bus channel
// R3 - Primary strap low subscriber, high line
// R4 - Secondary strap: low trunk, high line card
// R5 - Subscriber: awake falling edge interrupts, optional reset
// R6 - Reset out low on watchdog or command
// R7 - Buffered oscillator clock output, unsynchronised; here taken through the two-stage synchroniser and a register
// R8 - Received D-channel bits on activity output
// R9 - Inhibit pin or bit inverts echo bits
// R10 - Stop/go output, programmable polarity and length
// R11 - LED: host level or low when activated
// R12 - Board keeps straps stable after reset
// R13 - Bit clock half data clock, trunk 1.536MHz
`ifndef MISC_DEFS_VH
`define MISC_DEFS_VH
// Register word indices; byte address is four times the index
`define ADR_CONF      4'h0
`define ADR_AUX_DIR   4'h1
`define ADR_AUX_OUT   4'h2
`define ADR_AUX_IN    4'h3
`define ADR_STATUS    4'h4
`define ADR_IRQ_STAT  4'h5
`define ADR_IRQ_MASK  4'h6
// Configuration fields
`define CF_LED_AUTO   0
`define CF_LED_LEVEL  1
`define CF_INHIBIT    2
`define CF_SG_POL     3
`define CF_AWAKE_RST  4
`define CF_HOST_RST   5
`define CF_NT_SEL     6
`define CF_SG_LEN_LO  8
`define CF_SG_LEN_HI  15
`define CONF_RESET    32'h00000101
// Interrupt bits
`define IRQ_AWAKE     0
`define IRQ_WDOG      1
// Operating roles
`define ROLE_TE       2'h0
`define ROLE_LTT      2'h1
`define ROLE_LTS      2'h2
`define ROLE_NT       2'h3
// Reset pulse: time in ns and cycles at the clock period
`define RST_PULSE_NS  1000
`define CLK_PERIOD_NS 10
`define RST_PULSE_CYC (`RST_PULSE_NS / `CLK_PERIOD_NS)
// AXI response codes
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif
